/* File: design/rxr_pkg.sv */
// Shared constants and types for the receive ring DMA
package rxr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
    localparam int HDR_WORDS = 4;
    // Header word offsets from the frame base, in bytes
    localparam logic [ADDR_W-1:0] HDR_EVENT_OFS = 16'h0000;
    localparam logic [ADDR_W-1:0] HDR_STATUS_OFS = 16'h0002;
    localparam logic [ADDR_W-1:0] HDR_COUNT_OFS = 16'h0004;
    localparam logic [ADDR_W-1:0] HDR_NEXT_OFS = 16'h0006;
    localparam logic [DATA_W-1:0] EVT_NONE = 16'h0000;
    localparam logic [DATA_W-1:0] EVT_RX_DONE = 16'h0008;
    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_LOWER = 5'h04;
    localparam logic [4:0] REG_UPPER = 5'h08;
    localparam logic [4:0] REG_STOP = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_CUR = 5'h14;
    localparam logic [4:0] REG_BASE = 5'h18;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_DISCARD_BIT = 1;
    localparam int STAT_STOPPED_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [ADDR_W-1:0] LOWER_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] UPPER_RESET = 16'hfffe;
    localparam logic [ADDR_W-1:0] STOP_RESET = 16'h0000;
    // Status word bit positions
    localparam int SB_FRAME_START = 7;
    localparam int SB_ONE = 4;
    localparam int SB_OWN_ADDR = 1;
    localparam int SB_COLLISION = 0;
    localparam int SB_TYPE_LEN = 15;
    localparam int SB_GOOD = 13;
    localparam int SB_LENGTH_ERROR = 12;
    localparam int SB_CRC_ERR = 11;
    localparam int SB_ALIGN_ERR = 10;
    localparam int SB_OVERRUN = 8;

    typedef struct packed {
        logic frame_start_flag;
        logic own_address_match;
        logic receive_collision_seen;
        logic type_length_flag;
        logic receive_good;
        logic length_error;
        logic crc_error;
        logic alignment_error;
        logic overrun_error;
    } rxr_status_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DATA,
        ST_DROP,
        ST_HDR,
        ST_HALT
    } rxr_state_type;
endpackage

/* File: design/rxr_status_word.sv */
// Packs the per-frame receive status into one memory word
`timescale 1ns/1ps
`default_nettype none
module rxr_status_word (
    input wire rxr_pkg::rxr_status_type status_i,
    output logic [rxr_pkg::DATA_W-1:0] word_o
);
    always_comb begin
        word_o = '0;
        word_o[rxr_pkg::SB_FRAME_START] = status_i.frame_start_flag;
        word_o[rxr_pkg::SB_ONE] = 1'b1;
        word_o[rxr_pkg::SB_OWN_ADDR] = status_i.own_address_match;
        word_o[rxr_pkg::SB_COLLISION] = status_i.receive_collision_seen;
        word_o[rxr_pkg::SB_TYPE_LEN] = status_i.type_length_flag;
        word_o[rxr_pkg::SB_GOOD] = status_i.receive_good;
        word_o[rxr_pkg::SB_LENGTH_ERROR] = status_i.length_error;
        word_o[rxr_pkg::SB_CRC_ERR] = status_i.crc_error;
        word_o[rxr_pkg::SB_ALIGN_ERR] = status_i.alignment_error;
        word_o[rxr_pkg::SB_OVERRUN] = status_i.overrun_error;
    end
endmodule
`default_nettype wire

/* File: design/rxr_ring_dma.sv */
// Receive ring buffer DMA with Avalon-MM register slave
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rxr_ring_dma #(
    parameter int ADDR_W = rxr_pkg::ADDR_W,
    parameter int DATA_W = rxr_pkg::DATA_W
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Receive word stream
    input wire logic rx_valid_i,
    input wire logic [DATA_W-1:0] rx_data_i,
    input wire logic rx_last_i,
    input wire rxr_pkg::rxr_status_type rx_status_i,
    output logic rx_ready_o,
    // Local memory write port
    output logic mem_wr_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_data_o,
    input wire logic mem_wait_i,
    // Events
    output logic stopped_o,
    output logic eof_pulse_o
);
    ////////////////////////////////////////////////////////////////
    logic [1:0] ctrl_reg;
    logic [ADDR_W-1:0] lower_reg, upper_reg, stop_reg;
    logic [ADDR_W-1:0] cur_reg, base_reg;
    logic [ADDR_W-1:0] count_reg;
    logic stopped_reg;
    logic eof_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic mem_wr_reg;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic [DATA_W-1:0] mem_data_reg;
    logic [2:0] hdr_idx_reg;
    rxr_pkg::rxr_status_type stat_reg;
    rxr_pkg::rxr_state_type state_reg;
    logic [DATA_W-1:0] status_word;
    logic mem_free, take, bad_frame, wr_hit, stop_wr, stat_clr;
    logic [ADDR_W-1:0] data_start;

    // Ring address advance, wraps at the upper limit
    function automatic logic [ADDR_W-1:0] ring_next(input logic [ADDR_W-1:0] a,
                                                    input logic [ADDR_W-1:0] lo,
                                                    input logic [ADDR_W-1:0] hi);
        if (a == hi) begin
            ring_next = lo;
        end else begin
            ring_next = a + rxr_pkg::WORD_STEP;
        end
    endfunction

    // Header word address, wraps past the upper limit like the data
    function automatic logic [ADDR_W-1:0] ring_add(input logic [ADDR_W-1:0] a,
                                                   input logic [ADDR_W-1:0] ofs,
                                                   input logic [ADDR_W-1:0] lo,
                                                   input logic [ADDR_W-1:0] hi);
        logic [ADDR_W-1:0] room;
        room = hi - a;
        if (ofs > room) begin
            ring_add = lo + (ofs - room - rxr_pkg::WORD_STEP);
        end else begin
            ring_add = a + ofs;
        end
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [ADDR_W-1:0] lane_merge(input logic [ADDR_W-1:0] old,
                                                     input logic [31:0] wd,
                                                     input logic [3:0] be);
        lane_merge = old;
        if (be[0]) begin
            lane_merge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            lane_merge[15:8] = wd[15:8];
        end
    endfunction

    rxr_status_word u_status (
        .status_i(stat_reg),
        .word_o(status_word)
    );

    ////////////////////////////////////////////////////////////////
    // Register slave: answer one cycle after request
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
    assign avs_readdata_o = rdata_reg;
    assign stop_wr = avs_write_i && ack_reg && avs_address_i == rxr_pkg::REG_STOP;
    assign stat_clr = avs_write_i && ack_reg && avs_address_i == rxr_pkg::REG_STATUS
                      && avs_byteenable_i[0] && avs_writedata_i[rxr_pkg::STAT_STOPPED_BIT];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_i && !ack_reg) begin
            rdata_reg <= 32'h0000_0000;
            case (avs_address_i)
                rxr_pkg::REG_CTRL: rdata_reg[1:0] <= ctrl_reg;
                rxr_pkg::REG_LOWER: rdata_reg[ADDR_W-1:0] <= lower_reg;
                rxr_pkg::REG_UPPER: rdata_reg[ADDR_W-1:0] <= upper_reg;
                rxr_pkg::REG_STOP: rdata_reg[ADDR_W-1:0] <= stop_reg;
                rxr_pkg::REG_STATUS: begin
                    rdata_reg[rxr_pkg::STAT_STOPPED_BIT] <= stopped_reg;
                    rdata_reg[rxr_pkg::STAT_BUSY_BIT] <= state_reg != rxr_pkg::ST_IDLE;
                end
                rxr_pkg::REG_CUR: rdata_reg[ADDR_W-1:0] <= cur_reg;
                rxr_pkg::REG_BASE: rdata_reg[ADDR_W-1:0] <= base_reg;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg <= rxr_pkg::CTRL_RESET;
            lower_reg <= rxr_pkg::LOWER_RESET;
            upper_reg <= rxr_pkg::UPPER_RESET;
            stop_reg <= rxr_pkg::STOP_RESET;
        end else if (avs_write_i && ack_reg) begin
            case (avs_address_i)
                rxr_pkg::REG_CTRL: if (avs_byteenable_i[0]) ctrl_reg <= avs_writedata_i[1:0];
                rxr_pkg::REG_LOWER: lower_reg <= lane_merge(lower_reg, avs_writedata_i,
                                                            avs_byteenable_i);
                rxr_pkg::REG_UPPER: upper_reg <= lane_merge(upper_reg, avs_writedata_i,
                                                            avs_byteenable_i);
                rxr_pkg::REG_STOP: stop_reg <= lane_merge(stop_reg, avs_writedata_i,
                                                          avs_byteenable_i);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Receive DMA
    assign mem_free = !mem_wr_reg || !mem_wait_i;
    assign wr_hit = cur_reg == stop_reg;
    assign rx_ready_o = (state_reg == rxr_pkg::ST_DATA && mem_free && !wr_hit)
                        || state_reg == rxr_pkg::ST_DROP;
    assign take = rx_valid_i && rx_ready_o;
    assign bad_frame = ctrl_reg[rxr_pkg::CTRL_DISCARD_BIT] && !rx_status_i.receive_good;
    assign mem_wr_o = mem_wr_reg;
    assign mem_addr_o = mem_addr_reg;
    assign mem_data_o = mem_data_reg;
    assign stopped_o = stopped_reg;
    assign eof_pulse_o = eof_reg;

    always_comb begin
        data_start = base_reg;
        for (int i = 0; i < rxr_pkg::HDR_WORDS; i++) begin
            data_start = ring_next(data_start, lower_reg, upper_reg);
        end
    end

    // Sticky halt flag; hardware set wins over software clear
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stopped_reg <= 1'b0;
        end else if ((state_reg == rxr_pkg::ST_DATA || state_reg == rxr_pkg::ST_HDR)
                     && wr_hit && mem_free && (state_reg == rxr_pkg::ST_HDR || rx_valid_i)) begin
            stopped_reg <= 1'b1;
        end else if (stat_clr || stop_wr) begin
            stopped_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= rxr_pkg::ST_IDLE;
            cur_reg <= rxr_pkg::LOWER_RESET;
            base_reg <= rxr_pkg::LOWER_RESET;
            count_reg <= '0;
            hdr_idx_reg <= 3'h0;
            stat_reg <= '0;
            eof_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            mem_addr_reg <= '0;
            mem_data_reg <= '0;
        end else begin
            eof_reg <= 1'b0;
            if (mem_wr_reg && !mem_wait_i) begin
                mem_wr_reg <= 1'b0;
            end
            case (state_reg)
                rxr_pkg::ST_IDLE: begin
                    if (!ctrl_reg[rxr_pkg::CTRL_ENABLE_BIT]) begin
                        base_reg <= lower_reg;
                        cur_reg <= lower_reg;
                    end else if (rx_valid_i && !stopped_reg) begin
                        cur_reg <= data_start;
                        count_reg <= '0;
                        state_reg <= rxr_pkg::ST_DATA;
                    end
                end
                rxr_pkg::ST_DATA: begin
                    if (rx_valid_i && mem_free && wr_hit) begin
                        cur_reg <= base_reg;
                        state_reg <= rx_last_i ? rxr_pkg::ST_HALT : rxr_pkg::ST_DROP;
                    end else if (take) begin
                        mem_wr_reg <= 1'b1;
                        mem_addr_reg <= cur_reg;
                        mem_data_reg <= rx_data_i;
                        cur_reg <= ring_next(cur_reg, lower_reg, upper_reg);
                        count_reg <= count_reg + rxr_pkg::WORD_STEP;
                        if (rx_last_i) begin
                            stat_reg <= rx_status_i;
                            if (bad_frame) begin
                                cur_reg <= base_reg;
                                state_reg <= rxr_pkg::ST_IDLE;
                            end else begin
                                hdr_idx_reg <= 3'h0;
                                state_reg <= rxr_pkg::ST_HDR;
                            end
                        end
                    end
                end
                rxr_pkg::ST_DROP: begin
                    if (take && rx_last_i) begin
                        state_reg <= rxr_pkg::ST_HALT;
                    end
                end
                rxr_pkg::ST_HDR: begin
                    if (mem_free && hdr_idx_reg == 3'h0 && wr_hit) begin
                        cur_reg <= base_reg;
                        state_reg <= rxr_pkg::ST_HALT;
                    end else if (mem_free) begin
                        mem_wr_reg <= 1'b1;
                        hdr_idx_reg <= hdr_idx_reg + 3'h1;
                        case (hdr_idx_reg)
                            3'h0: begin
                                mem_addr_reg <= cur_reg;
                                mem_data_reg <= rxr_pkg::EVT_NONE;
                            end
                            3'h1: begin
                                mem_addr_reg <= ring_add(base_reg, rxr_pkg::HDR_NEXT_OFS,
                                                         lower_reg, upper_reg);
                                mem_data_reg <= cur_reg;
                            end
                            3'h2: begin
                                mem_addr_reg <= ring_add(base_reg, rxr_pkg::HDR_COUNT_OFS,
                                                         lower_reg, upper_reg);
                                mem_data_reg <= count_reg;
                            end
                            3'h3: begin
                                mem_addr_reg <= ring_add(base_reg, rxr_pkg::HDR_STATUS_OFS,
                                                         lower_reg, upper_reg);
                                mem_data_reg <= status_word;
                            end
                            default: begin
                                mem_addr_reg <= base_reg + rxr_pkg::HDR_EVENT_OFS;
                                mem_data_reg <= rxr_pkg::EVT_RX_DONE;
                                base_reg <= cur_reg;
                                eof_reg <= 1'b1;
                                state_reg <= rxr_pkg::ST_IDLE;
                            end
                        endcase
                    end
                end
                rxr_pkg::ST_HALT: begin
                    if (!stopped_reg) begin
                        state_reg <= rxr_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= rxr_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    no_write_stop_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        take && state_reg == rxr_pkg::ST_DATA |=> mem_addr_o != $past(stop_reg))
        else $error("data taken at stop pointer");
    stop_halts_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_reg == rxr_pkg::ST_DATA && rx_valid_i && mem_free && wr_hit
        |=> stopped_reg && !mem_wr_reg)
        else $error("stop pointer did not halt");
    wrap_upper_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        take && state_reg == rxr_pkg::ST_DATA && !rx_last_i && cur_reg == upper_reg
        |=> cur_reg == lower_reg)
        else $error("no wrap at upper limit");
    sequential_data_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        take && state_reg == rxr_pkg::ST_DATA && !rx_last_i && cur_reg != upper_reg
        |=> cur_reg == $past(cur_reg) + rxr_pkg::WORD_STEP)
        else $error("data not stored sequentially");
    data_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        take && state_reg == rxr_pkg::ST_DATA
        |=> mem_wr_o && mem_data_o == $past(rx_data_i) && mem_addr_o == $past(cur_reg))
        else $error("data write lost");
    discard_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        take && rx_last_i && state_reg == rxr_pkg::ST_DATA && bad_frame && !wr_hit
        |=> cur_reg == $past(base_reg) && state_reg == rxr_pkg::ST_IDLE)
        else $error("bad frame not discarded");
    header_after_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_reg == rxr_pkg::ST_HDR && $past(state_reg) != rxr_pkg::ST_HDR
        |-> $past(take) && $past(rx_last_i))
        else $error("header before frame end");
    eof_idle_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        eof_pulse_o |-> state_reg == rxr_pkg::ST_IDLE && mem_wr_o
        && mem_data_o == rxr_pkg::EVT_RX_DONE)
        else $error("end pulse without event word");
    status_one_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        status_word[rxr_pkg::SB_ONE] && !status_word[6] && !status_word[9]
        && status_word[rxr_pkg::SB_GOOD] == stat_reg.receive_good)
        else $error("status word malformed");
    stat_fields_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        status_word[rxr_pkg::SB_OVERRUN] == stat_reg.overrun_error
        && status_word[14] == 1'b0)
        else $error("status high byte wrong");
endmodule
`default_nettype wire

/* File: verif/rxr_mem_model.sv */
// Local buffer memory model that can stall the receive DMA writes
`timescale 1ns/1ps
`default_nettype none
module rxr_mem_model (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic mem_wr_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_data_i,
    input wire logic slow_i,
    output logic mem_wait_o,
    output logic took_o
);
    logic [15:0] mem_reg [0:32767];
    logic [3:0] lfsr_reg;
    assign took_o = mem_wr_i & ~mem_wait_o;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lfsr_reg <= 4'h9;
            mem_wait_o <= 1'b0;
        end else begin
            lfsr_reg <= {lfsr_reg[2:0], lfsr_reg[3] ^ lfsr_reg[2]};
            mem_wait_o <= slow_i & lfsr_reg[0];
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (took_o) begin
            mem_reg[mem_addr_i[15:1]] <= mem_data_i;
        end
    end
endmodule
`default_nettype wire

/* File: verif/rxr_ring_dma_tb.sv */
// Self-checking bench for the receive ring DMA
`timescale 1ns/1ps
`default_nettype none
module rxr_ring_dma_tb;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, rx_ready_o, mem_wr_o, mem_wait_i, stopped_o, eof_pulse_o, took;
    logic rx_valid_i = 1'b0;
    logic rx_last_i = 1'b0;
    logic slow = 1'b0;
    logic disc = 1'b0;
    logic [15:0] rx_data_i = 16'h0;
    logic [15:0] mem_addr_o, mem_data_o, lo, hi, base;
    rxr_pkg::rxr_status_type rx_status_i = '0;
    logic [47:0] exp_q[$];
    logic [4:0] ra [6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h1c};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'hfffe, 32'h0, 32'h0, 32'h0};
    int bad_count = 0;
    int n_tests = 0;
    int seed = 1450;
    int eof_seen = 0;
    int eof_exp = 0;

    rxr_ring_dma uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_last_i(rx_last_i),
        .rx_status_i(rx_status_i), .rx_ready_o(rx_ready_o), .mem_wr_o(mem_wr_o),
        .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .mem_wait_i(mem_wait_i),
        .stopped_o(stopped_o), .eof_pulse_o(eof_pulse_o));
    rxr_mem_model mem (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .mem_wr_i(mem_wr_o),
        .mem_addr_i(mem_addr_o), .mem_data_i(mem_data_o), .slow_i(slow),
        .mem_wait_o(mem_wait_i), .took_o(took));

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_tests++;
        if ((got & m) !== (exp & m)) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do begin
            @(posedge core_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(d, e, m);
    endtask

    function automatic logic [15:0] nx(input logic [15:0] a);
        return (a == hi) ? lo : a + 16'h0002;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Streams one frame, queueing each expected data write before its word and, unless the frame is stopped or discarded, the header writes after
    task automatic frame(input int n, input logic err, input int stop_at);
        rxr_pkg::rxr_status_type s;
        logic [15:0] a, w;
        int k;
        s = rxr_pkg::rxr_status_type'($random(seed));
        {s.receive_good, s.crc_error} = {~err, err};
        {s.length_error, s.alignment_error, s.overrun_error} = 3'b000;
        a = nx(nx(nx(nx(base))));
        w = a;
        for (k = 0; k < stop_at; k++) w = nx(w);
        if (stop_at < n) wr(rxr_pkg::REG_STOP, {16'h0, w});
        @(posedge core_clk_i);
        for (k = 0; k < n; k++) begin
            w = 16'($random(seed));
            if (k < stop_at) begin
                exp_q.push_back({a, w, 16'hffff});
                a = nx(a);
            end
            rx_valid_i <= 1'b1;
            rx_data_i <= w;
            rx_last_i <= (k == n - 1);
            rx_status_i <= s;
            do begin
                @(posedge core_clk_i);
            end while (rx_ready_o !== 1'b1);
        end
        rx_valid_i <= 1'b0;
        rx_last_i <= 1'b0;
        if (stop_at >= n && !(err && disc)) begin
            exp_q.push_back({a, rxr_pkg::EVT_NONE, 16'hffff});
            exp_q.push_back({nx(nx(nx(base))), a, 16'hffff});
            exp_q.push_back({nx(nx(base)), 16'(2 * n), 16'hffff});
            exp_q.push_back({nx(base), s.type_length_flag, 1'b0, s.receive_good, s.length_error,
                s.crc_error, s.alignment_error, 1'b0, s.overrun_error, s.frame_start_flag,
                2'b00, 1'b1, 2'b00, s.own_address_match, s.receive_collision_seen, 16'hff93});
            exp_q.push_back({base, rxr_pkg::EVT_RX_DONE, 16'hffff});
            base = a;
            eof_exp++;
        end
    endtask

    task automatic drain();
        int k;
        for (k = 0; k < 400 && exp_q.size() != 0; k++) @(posedge core_clk_i);
        repeat (4) @(posedge core_clk_i);
        chk(exp_q.size(), 0, 32'hffffffff);
    endtask

    always @(posedge core_clk_i) begin
        if (arst_n_i && took === 1'b1) begin
            if (exp_q.size() != 0) begin
                chk({mem_addr_o, mem_data_o}, exp_q[0][47:16], {16'hffff, exp_q[0][15:0]});
                void'(exp_q.pop_front());
            end else begin
                chk(1, 0, 1);
            end
        end
        if (arst_n_i && eof_pulse_o === 1'b1) begin
            eof_seen++;
            chk({mem_wr_o, mem_data_o}, {1'b1, rxr_pkg::EVT_RX_DONE}, 32'h1ffff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("mismatches %0d comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk_i);
        bad_count++;
        results();
    end

    initial begin
        repeat (12) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i], 32'hffffffff);
        wr(rxr_pkg::REG_CUR, 32'h1234);
        rd(rxr_pkg::REG_CUR, 32'h0, 32'hffff);
        lo = 16'h0100;
        hi = 16'h013e;
        base = lo;
        wr(rxr_pkg::REG_LOWER, {16'h0, lo});
        wr(rxr_pkg::REG_UPPER, {16'h0, hi});
        wr(rxr_pkg::REG_CTRL, 32'h1);
        for (int f = 0; f < 12; f++) begin
            slow <= (f >= 6);
            frame(1 + ($unsigned($random(seed)) % 8), $random(seed) & 1, 99);
        end
        drain();
        rd(rxr_pkg::REG_BASE, {16'h0, base}, 32'hffff);
        wr(rxr_pkg::REG_CTRL, 32'h3);
        disc = 1'b1;
        frame(5, 1'b1, 99);
        frame(3, 1'b0, 99);
        drain();
        frame(6, 1'b0, 2);
        drain();
        chk(stopped_o, 1'b1, 1);
        rd(rxr_pkg::REG_STATUS, 32'h1, 32'h1);
        wr(rxr_pkg::REG_STOP, 32'h0);
        repeat (2) @(posedge core_clk_i);
        chk(stopped_o, 1'b0, 1);
        frame(4, 1'b0, 99);
        drain();
        chk(eof_seen, eof_exp, 32'hffffffff);
        results();
    end
endmodule
`default_nettype wire
